/* hw/azr_consts.svh */
`ifndef AZR_CONSTS_SVH
`define AZR_CONSTS_SVH

// Register byte addresses on the plain register port
`define AZR_ADDR_CTRL 8'h00
`define AZR_ADDR_HOME_SPEED 8'h04
`define AZR_ADDR_CREEP_SPEED 8'h08
`define AZR_ADDR_DIRECTION 8'h0C
`define AZR_ADDR_ZERO_ADDRESS 8'h10
`define AZR_ADDR_MARKER_COUNT 8'h14
`define AZR_ADDR_MODE 8'h18
`define AZR_ADDR_POLARITY 8'h1C
`define AZR_ADDR_STATUS 8'h20
`define AZR_ADDR_POSITION 8'h24

// Field positions
`define AZR_CTRL_HOME_BIT 4
`define AZR_POL_FWD_LIMIT_BIT 0
`define AZR_POL_REV_LIMIT_BIT 1
`define AZR_POL_NEAR_BIT 2
`define AZR_STAT_DONE_BIT 0
`define AZR_STAT_BUSY_BIT 1

// Homing mode codes
`define AZR_MODE_LEADING 2'h0
`define AZR_MODE_TRAILING 2'h1
`define AZR_MODE_NO_SWITCH 2'h2

// Reset values of the parameters
`define AZR_RST_HOME_SPEED 16'h0064
`define AZR_RST_CREEP_SPEED 16'h03E8
`define AZR_RST_DIRECTION 1'h1
`define AZR_RST_ZERO_ADDRESS 32'h0000_0000
`define AZR_RST_MARKER_COUNT 16'h0001
`define AZR_RST_MODE 2'h0
`define AZR_RST_POLARITY 3'h0

// Deviation clear pulse: time in ns, cycles at 8 ns, rounded up
`define AZR_CLK_PERIOD_NS 8
`define AZR_CLEAR_TIME_NS 20000
`define AZR_CLEAR_CYCLES \
  ((`AZR_CLEAR_TIME_NS + `AZR_CLK_PERIOD_NS - 1) / `AZR_CLK_PERIOD_NS)

`endif

/* hw/azr_pkg.sv */
package azr_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    AZR_IDLE,
    AZR_ESCAPE,
    AZR_FAST,
    AZR_SEARCH_BACK,
    AZR_SEARCH_PASS,
    AZR_CREEP,
    AZR_CLEAR
  } azr_state_t;

  // Switch inputs travel together
  typedef struct packed {
    logic forward_limit_switch; // Forward stroke end
    logic reverse_limit_switch; // Reverse stroke end
    logic near_point_switch; // Near-point cam switch
  } azr_switch_t;

  // Command sources travel together
  typedef struct packed {
    logic homing_request_input; // External homing button level
    logic homing_instruction; // Homing instruction executing
    logic subtask_homing_request; // Relay set by subtask
    logic subtask_running; // Subtask in automatic run
    logic manual_operating_mode; // High in manual mode
    logic program_end_step; // Program waits at end step
  } azr_command_t;

  // Whole state of the sequencer
  typedef struct packed {
    azr_state_t st; // Sequence state
    logic [31:0] position; // Present-position counter
    logic [15:0] home_speed; // Homing pulse period, cycles
    logic [15:0] creep_speed; // Creep pulse period, cycles
    logic direction; // 1 homes in reverse
    logic [31:0] zero_address; // Loaded at completion
    logic [15:0] marker_count; // Markers to count
    logic [1:0] mode; // Count start select
    logic [2:0] polarity; // 1 marks normally-closed
    logic [15:0] divider; // Pulse period counter
    logic [11:0] clear_cnt; // Clear pulse length counter
    logic [15:0] markers; // Markers seen so far
    logic counting; // Marker counting armed
    logic mk_s1; // Marker sync stage 1
    logic mk_s2; // Marker sync stage 2
    logic mk_q; // Marker delayed for edge
    logic near_q; // Near-point delayed for edge
    logic req_q; // External request delayed
    logic done; // Homing-complete flag
    logic fwd_pulse; // Forward pulse out
    logic rev_pulse; // Reverse pulse out
    logic clear_out; // Deviation clear out
    logic busy; // Sequence running
    logic [31:0] rdata; // Read data out
  } azr_regs_t;

endpackage

/* hw/azr_sequencer.sv */
// Operation
// R1 - Count position up forward, down reverse
// R2 - Position lost at power-up; home first
// R3 - Travel homing direction at homing speed
// R4 - Near-point switch slows to creep speed
// R5 - Count markers, stop at set number
// R6 - Pulse clear output, load zero address
// R7 - Mode picks leading or trailing count
// R8 - Mode 2: no motion, clear and load
// R9 - External input: manual always, auto end
// R10 - Instruction homes only in automatic mode
// R11 - Subtask relay homes only automatic subtask
// R12 - Host bit 4 starts homing; the code takes it only in manual mode or at the end step
// R13 - Done flag clears on start, sets end
// R14 - Done flag survives manual to automatic
// R15 - Past cam: limit, forward past, home
// R16 - Switch polarities set by parameter
// R17 - Without limits operator clears cam first
// R18 - Start on cam: escape off first
// R19 - Escape needs no limit switch
// R20 - Markers synced, counted once per rise
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "azr_consts.svh"

module azr_sequencer (
  input wire logic sys_clk, // 125 MHz clock
  input wire logic srst, // Synchronous reset, high
  input wire logic [7:0] address, // Register byte address
  input wire logic [31:0] wdata, // Register write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire azr_pkg::azr_switch_t switches, // Limit and near-point
  input wire azr_pkg::azr_command_t commands, // Homing command sources
  input wire logic zero_marker_pulse, // Encoder zero marker
  output logic [31:0] rdata, // Read data, cycle after rd
  output logic fwd_pulse, // Forward pulse, one cycle
  output logic rev_pulse, // Reverse pulse, one cycle
  output logic deviation_clear_output, // Clear to amplifier
  output logic homing_done_flag, // Homing complete
  output logic busy // Sequence running
);

  // Registered state and its next value
  azr_pkg::azr_regs_t s;
  azr_pkg::azr_regs_t next_s;

  // Switch levels after polarity correction
  logic fwd_lim; // Forward limit active
  logic rev_lim; // Reverse limit active
  logic near; // Near-point active
  logic near_rise; // Near-point leading edge
  logic near_fall; // Near-point trailing edge
  logic mk_rise; // Synchronised marker edge
  logic accept_now; // Manual, or auto at end step
  logic start; // Accepted homing command
  logic host_go; // Host command bit written
  logic toward_lim; // Limit in homing direction
  logic run; // Pulse train enabled
  logic run_rev; // Pulse train goes reverse
  logic [15:0] period; // Active pulse period
  logic [15:0] markers_inc; // Marker count plus one

  // Polarity, edges and command qualification
  always_comb
  begin
    // R16 polarity per switch
    fwd_lim = switches.forward_limit_switch
      ^ s.polarity[`AZR_POL_FWD_LIMIT_BIT];
    rev_lim = switches.reverse_limit_switch
      ^ s.polarity[`AZR_POL_REV_LIMIT_BIT];
    near = switches.near_point_switch ^ s.polarity[`AZR_POL_NEAR_BIT];
    near_rise = near & ~s.near_q;
    near_fall = ~near & s.near_q;
    // R20 edge after sync
    mk_rise = s.mk_s2 & ~s.mk_q;
    markers_inc = s.markers + 16'h0001;
    toward_lim = s.direction ? rev_lim : fwd_lim;
    accept_now = commands.manual_operating_mode
      | commands.program_end_step;
    host_go = wr && (address == `AZR_ADDR_CTRL)
      && wdata[`AZR_CTRL_HOME_BIT];
    // Commands are only taken while idle; a running sequence is
    // never restarted, so a held relay cannot retrigger it mid-way.
    start = (s.st == azr_pkg::AZR_IDLE) && (
      // R9 external input window
      ((commands.homing_request_input & ~s.req_q) & accept_now)
      // R10 instruction, auto only
      | (commands.homing_instruction
        & ~commands.manual_operating_mode)
      // R11 subtask relay, auto only
      | (commands.subtask_homing_request & commands.subtask_running
        & ~commands.manual_operating_mode)
      // R12 host bit window
      | (host_go & accept_now));
  end

  // Motion selection per state
  always_comb
  begin
    run = 1'b0;
    run_rev = s.direction;
    period = s.home_speed;
    unique case (s.st)
      azr_pkg::AZR_IDLE:
      begin
        run = 1'b0;
      end
      azr_pkg::AZR_ESCAPE, azr_pkg::AZR_SEARCH_BACK,
      azr_pkg::AZR_SEARCH_PASS:
      begin
        // Away from the homing direction
        run = 1'b1;
        run_rev = ~s.direction;
      end
      azr_pkg::AZR_FAST:
      begin
        // R3 homing speed, direction
        run = 1'b1;
      end
      azr_pkg::AZR_CREEP:
      begin
        // R4 creep speed
        run = 1'b1;
        period = s.creep_speed;
      end
      azr_pkg::AZR_CLEAR:
      begin
        run = 1'b0;
      end
    endcase
  end

  // Next-state logic for the whole block
  always_comb
  begin
    next_s = s;
    next_s.fwd_pulse = 1'b0;
    next_s.rev_pulse = 1'b0;
    next_s.rdata = 32'h0000_0000;
    // Marker synchroniser, stage 1 only feeds stage 2
    next_s.mk_s1 = zero_marker_pulse;
    next_s.mk_s2 = s.mk_s1;
    next_s.mk_q = s.mk_s2;
    next_s.near_q = near;
    next_s.req_q = commands.homing_request_input;

    // Register writes
    if (wr)
    begin
      case (address)
        `AZR_ADDR_HOME_SPEED: next_s.home_speed = wdata[15:0];
        `AZR_ADDR_CREEP_SPEED: next_s.creep_speed = wdata[15:0];
        `AZR_ADDR_DIRECTION: next_s.direction = wdata[0];
        `AZR_ADDR_ZERO_ADDRESS: next_s.zero_address = wdata;
        `AZR_ADDR_MARKER_COUNT: next_s.marker_count = wdata[15:0];
        `AZR_ADDR_MODE: next_s.mode = wdata[1:0];
        `AZR_ADDR_POLARITY: next_s.polarity = wdata[2:0];
        default:
        begin
          // Control word and read-only words store nothing
        end
      endcase
    end

    // Register reads, answered in the next cycle
    if (rd)
    begin
      case (address)
        `AZR_ADDR_HOME_SPEED: next_s.rdata = {16'h0000, s.home_speed};
        `AZR_ADDR_CREEP_SPEED: next_s.rdata = {16'h0000, s.creep_speed};
        `AZR_ADDR_DIRECTION: next_s.rdata = {31'h0, s.direction};
        `AZR_ADDR_ZERO_ADDRESS: next_s.rdata = s.zero_address;
        `AZR_ADDR_MARKER_COUNT:
          next_s.rdata = {16'h0000, s.marker_count};
        `AZR_ADDR_MODE: next_s.rdata = {30'h0, s.mode};
        `AZR_ADDR_POLARITY: next_s.rdata = {29'h0, s.polarity};
        `AZR_ADDR_STATUS:
        begin
          next_s.rdata[`AZR_STAT_DONE_BIT] = s.done;
          next_s.rdata[`AZR_STAT_BUSY_BIT] = s.busy;
        end
        `AZR_ADDR_POSITION: next_s.rdata = s.position;
        default:
        begin
          // Unmapped and control word read as zero
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Pulse train; a zero period is treated as one cycle
    if (run)
    begin
      if (s.divider == 16'h0000)
      begin
        next_s.divider = (period == 16'h0000) ? 16'h0000
          : period - 16'h0001;
        // R1 track every pulse
        if (run_rev)
        begin
          next_s.rev_pulse = 1'b1;
          next_s.position = s.position - 32'h0000_0001;
        end
        else
        begin
          next_s.fwd_pulse = 1'b1;
          next_s.position = s.position + 32'h0000_0001;
        end
      end
      else
      begin
        next_s.divider = s.divider - 16'h0001;
      end
    end
    else
    begin
      // First pulse leaves at once when motion begins
      next_s.divider = 16'h0000;
    end

    // Sequencer
    unique case (s.st)
      azr_pkg::AZR_IDLE:
      begin
        // R14 done only moves on a start
        if (start)
        begin
          // R13 clear on accepted start
          next_s.done = 1'b0;
          next_s.busy = 1'b1;
          next_s.markers = 16'h0000;
          next_s.counting = 1'b0;
          if (s.mode == `AZR_MODE_NO_SWITCH)
          begin
            // R8 home in place
            next_s.st = azr_pkg::AZR_CLEAR;
            next_s.position = s.zero_address;
            next_s.done = 1'b1;
            next_s.clear_out = 1'b1;
            next_s.clear_cnt = 12'(`AZR_CLEAR_CYCLES - 1);
          end
          else if (near)
          begin
            // R18 escape off cam first
            next_s.st = azr_pkg::AZR_ESCAPE;
          end
          else
          begin
            next_s.st = azr_pkg::AZR_FAST;
          end
        end
      end
      azr_pkg::AZR_ESCAPE:
      begin
        // R19 leaves by switch level only, no limit used
        if (!near)
        begin
          next_s.st = azr_pkg::AZR_FAST;
        end
      end
      azr_pkg::AZR_FAST:
      begin
        if (near_rise)
        begin
          // R4 slow at leading edge
          next_s.st = azr_pkg::AZR_CREEP;
          // R7 leading-edge count start
          next_s.counting = (s.mode == `AZR_MODE_LEADING);
        end
        else if (toward_lim)
        begin
          // R15 cam passed, search back
          next_s.st = azr_pkg::AZR_SEARCH_BACK;
        end
      end
      azr_pkg::AZR_SEARCH_BACK:
      begin
        // R15 run back onto the cam
        if (near)
        begin
          next_s.st = azr_pkg::AZR_SEARCH_PASS;
        end
      end
      azr_pkg::AZR_SEARCH_PASS:
      begin
        // R15 clear cam, then home again
        if (!near)
        begin
          next_s.st = azr_pkg::AZR_FAST;
        end
      end
      azr_pkg::AZR_CREEP:
      begin
        // R7 trailing-edge count start
        if (near_fall && (s.mode == `AZR_MODE_TRAILING))
        begin
          next_s.counting = 1'b1;
        end
        // R5 count markers to target
        if (s.counting && mk_rise)
        begin
          next_s.markers = markers_inc;
          if (markers_inc >= s.marker_count)
          begin
            // R6 load zero, start clear
            next_s.st = azr_pkg::AZR_CLEAR;
            next_s.position = s.zero_address;
            // R13 done with the load
            next_s.done = 1'b1;
            // R5 no step leaves with the stop, it would miss the count
            next_s.fwd_pulse = 1'b0;
            next_s.rev_pulse = 1'b0;
            next_s.clear_out = 1'b1;
            next_s.clear_cnt = 12'(`AZR_CLEAR_CYCLES - 1);
          end
        end
      end
      azr_pkg::AZR_CLEAR:
      begin
        // R6 hold clear pulse length
        if (s.clear_cnt == 12'h000)
        begin
          next_s.clear_out = 1'b0;
          next_s.busy = 1'b0;
          next_s.st = azr_pkg::AZR_IDLE;
        end
        else
        begin
          next_s.clear_cnt = s.clear_cnt - 12'h001;
        end
      end
    endcase
  end

  // State register; reset leaves the axis unhomed
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s <= '0;
      s.st <= azr_pkg::AZR_IDLE;
      s.home_speed <= `AZR_RST_HOME_SPEED;
      s.creep_speed <= `AZR_RST_CREEP_SPEED;
      s.direction <= `AZR_RST_DIRECTION;
      s.zero_address <= `AZR_RST_ZERO_ADDRESS;
      s.marker_count <= `AZR_RST_MARKER_COUNT;
      s.mode <= `AZR_RST_MODE;
      s.polarity <= `AZR_RST_POLARITY;
      // R2 position invalid until homed
      s.done <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign rdata = s.rdata;
  assign fwd_pulse = s.fwd_pulse;
  assign rev_pulse = s.rev_pulse;
  assign deviation_clear_output = s.clear_out;
  assign homing_done_flag = s.done;
  assign busy = s.busy;

endmodule

/* test/azr_sequencer_props.sv */
`timescale 1ns/1ps
`include "azr_consts.svh"
// Timing relations seen at the sequencer ports
module azr_sequencer_props (
  input wire logic sys_clk, // Clock
  input wire logic srst, // Synchronous reset
  input wire logic rd, // Read strobe
  input wire logic [31:0] rdata, // Read data
  input wire logic fwd_pulse, // Forward step
  input wire logic rev_pulse, // Reverse step
  input wire logic deviation_clear_output, // Clear to amplifier
  input wire logic homing_done_flag, // Done flag
  input wire logic busy // Sequence running
);
  logic [11:0] clr_len; // Cycles the clear output has stood
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // Length of the present clear pulse, zero while it is low
  always_ff @(posedge sys_clk)
  begin
    if (srst || !deviation_clear_output)
      clr_len <= 12'h000;
    else
      clr_len <= clr_len + 12'h001;
  end
  a_step_exclusive:
    assert property (!(fwd_pulse && rev_pulse))
    else $error("forward and reverse step together");
  a_step_busy:
    assert property ((fwd_pulse || rev_pulse) |-> busy)
    else $error("step while idle");
  a_clear_quiet:
    assert property (deviation_clear_output |-> !fwd_pulse && !rev_pulse)
    else $error("step during clear pulse");
  a_clear_length:
    assert property ($fell(deviation_clear_output)
      |-> clr_len == 12'(`AZR_CLEAR_CYCLES))
    else $error("clear pulse length wrong");
  a_clear_ends:
    assert property ($fell(busy) |-> $fell(deviation_clear_output))
    else $error("busy fell apart from clear");
  a_clear_with_done:
    assert property ($rose(deviation_clear_output)
      |-> homing_done_flag && busy)
    else $error("clear rose without done");
  a_done_drop:
    assert property ($fell(homing_done_flag) |-> $rose(busy))
    else $error("done fell without a start");
  a_start_clears:
    assert property ($rose(busy)
      |-> !homing_done_flag || deviation_clear_output)
    else $error("done still set at start");
  a_done_holds:
    assert property (homing_done_flag && !busy |=> homing_done_flag || busy)
    else $error("done lost while idle");
  // Read data stands only after a read
  a_read_idle:
    assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data without read");
endmodule

bind azr_sequencer azr_sequencer_props i_props (
  .sys_clk, .srst, .rd, .rdata, .fwd_pulse, .rev_pulse,
  .deviation_clear_output, .homing_done_flag, .busy
);

/* test/azr_axis_model.sv */
`timescale 1ns/1ps
// Axis mechanics: amplifier follows steps, cam and stroke switches
module azr_axis_model (
  input wire logic sys_clk, // Clock
  input wire logic fwd_pulse, // Forward step
  input wire logic rev_pulse, // Reverse step
  input wire logic [2:0] pol, // Contact type, 1 normally-closed
  output azr_pkg::azr_switch_t switches, // Raw switch levels
  output logic zero_marker_pulse // Encoder marker
);
  int mpos = 40; // Table position in steps, set by the bench
  always @(posedge sys_clk)
  begin
    if (fwd_pulse)
      mpos <= mpos + 1;
    else if (rev_pulse)
      mpos <= mpos - 1;
  end
  assign switches = {mpos >= 60, mpos <= 0, mpos >= 10 && mpos <= 19} ^ pol;
  // Marker stands high on every fourth step, also at rest
  assign zero_marker_pulse = mpos[1:0] == 2'h0;
endmodule

/* test/azr_sequencer_tb_top.sv */
`timescale 1ns/1ps
`include "azr_consts.svh"
module azr_sequencer_tb_top;
  localparam logic [31:0] ZADDR = 32'h0000_1234; // Zero point used
  logic sys_clk = 1'b0; // Bench clock
  logic srst = 1'b1; // Reset, held at start
  logic [7:0] address = 8'h00; // Register address
  logic [31:0] wdata = 32'h0000_0000; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  azr_pkg::azr_command_t commands = '0; // Command sources
  logic [2:0] pol = 3'h0; // Contact type in the model
  azr_pkg::azr_switch_t switches; // Raw switches
  logic zero_marker_pulse; // Encoder marker
  logic [31:0] rdata; // Read data
  logic fwd_pulse; // Forward step
  logic rev_pulse; // Reverse step
  logic deviation_clear_output; // Clear to amplifier
  logic homing_done_flag; // Done flag
  logic busy; // Sequence running
  int bad_count = 0; // Mismatches
  int checked = 0; // Comparisons
  int snap; // Model position at a read
  logic [31:0] got; // Last read value
  // Reset table: addresses and values, unmapped last
  logic [7:0] ra [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
    8'h18, 8'h1C, 8'h20, 8'h24, 8'h30};
  logic [31:0] rv [11] = '{0, `AZR_RST_HOME_SPEED, `AZR_RST_CREEP_SPEED,
    `AZR_RST_DIRECTION, `AZR_RST_ZERO_ADDRESS, `AZR_RST_MARKER_COUNT,
    `AZR_RST_MODE, `AZR_RST_POLARITY, 0, 0, 0};
  // Start cases: bit6 host, then request, instr, relay, run, manual, end
  logic [6:0] cs [10] = '{7'h22, 7'h20, 7'h21, 7'h10, 7'h12, 7'h0C,
    7'h0E, 7'h42, 7'h40, 7'h41};
  logic [9:0] ce = 10'b10_1101_0101; // Accepted, case 0 at the top

  azr_sequencer i_dut (.sys_clk, .srst, .address, .wdata, .wr, .rd,
    .switches, .commands, .zero_marker_pulse, .rdata, .fwd_pulse,
    .rev_pulse, .deviation_clear_output, .homing_done_flag, .busy);
  azr_axis_model i_model (.sys_clk, .fwd_pulse, .rev_pulse, .pol,
    .switches, .zero_marker_pulse);

  // Free running clock
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] s);
    checked++;
    if (s !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, s);
    end
  endtask

  // One write cycle, then a quiet cycle so strobes never merge
  task wreg(input logic [7:0] a, input logic [31:0] d);
    address <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Read data stands in the cycle after the strobe only
  task rreg(input logic [7:0] a, output logic [31:0] d);
    address <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    // Sampled mid-cycle, where data and model have settled
    @(negedge sys_clk);
    d = rdata;
    snap = i_model.mpos;
    @(posedge sys_clk);
  endtask

  // Bounded wait for the sequence to finish
  task wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("idle", 0, busy);
  endtask

  // Homing from the external button in manual mode
  task home(input int start, input logic [31:0] dir, input logic [31:0] mode,
    input logic [2:0] p, input int stop);
    i_model.mpos <= start;
    pol <= p;
    wreg(`AZR_ADDR_DIRECTION, dir);
    wreg(`AZR_ADDR_MODE, mode);
    wreg(`AZR_ADDR_POLARITY, {29'h0, p});
    commands <= azr_pkg::azr_command_t'(6'h22);
    @(posedge sys_clk);
    commands <= azr_pkg::azr_command_t'(6'h02);
    @(posedge sys_clk);
    chk("busy at start", 1, busy);
    chk("done at start", 0, homing_done_flag);
    repeat (20) @(posedge sys_clk);
    rreg(`AZR_ADDR_POSITION, got);
    chk("moving position", ZADDR + snap - start, got);
    wait_idle;
    chk("stop position", stop, i_model.mpos);
    chk("done", 1, homing_done_flag);
    rreg(`AZR_ADDR_POSITION, got);
    chk("loaded position", ZADDR, got);
    $display("homing run from %0d finished", start);
  endtask

  task tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    #480_000;
    bad_count++;
    tally_and_finish;
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    wreg(`AZR_ADDR_POSITION, 32'hFFFF_FFFF);
    wreg(`AZR_ADDR_STATUS, 32'hFFFF_FFFF);
    for (int i = 0; i < 11; i++)
    begin
      rreg(ra[i], got);
      chk("reset value", rv[i], got);
    end
    $display("reset values done");
    wreg(`AZR_ADDR_HOME_SPEED, 32'h0000_0004);
    wreg(`AZR_ADDR_CREEP_SPEED, 32'h0000_0008);
    wreg(`AZR_ADDR_MARKER_COUNT, 32'h0000_0002);
    wreg(`AZR_ADDR_ZERO_ADDRESS, ZADDR);
    wreg(`AZR_ADDR_MODE, 32'h0000_0002);
    for (int i = 0; i < 10; i++)
    begin
      commands <= azr_pkg::azr_command_t'(cs[i][5:0] & 6'h1F);
      @(posedge sys_clk);
      commands <= azr_pkg::azr_command_t'(cs[i][5:0]);
      if (cs[i][6])
        wreg(`AZR_ADDR_CTRL, 32'h0000_0010);
      else
        @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      chk("start accepted", ce[9 - i], busy);
      chk("clear pulse", ce[9 - i], deviation_clear_output);
      commands <= '0;
      wait_idle;
      chk("done kept", 1, homing_done_flag);
    end
    chk("no motion", 40, i_model.mpos);
    rreg(`AZR_ADDR_POSITION, got);
    chk("zero address", ZADDR, got);
    $display("start sources done");
    home(40, 1, 0, 3'h0, 12);
    home(40, 1, 1, 3'h0, 4);
    home(15, 1, 0, 3'h0, 12);
    home(5, 1, 0, 3'h0, 12);
    home(40, 1, 0, 3'h7, 12);
    home(2, 0, 0, 3'h0, 16);
    // Reset in motion must forget the home
    commands <= azr_pkg::azr_command_t'(6'h22);
    @(posedge sys_clk);
    commands <= azr_pkg::azr_command_t'(6'h02);
    repeat (30) @(posedge sys_clk);
    chk("busy before reset", 1, busy);
    srst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk("busy after reset", 0, busy);
    chk("done after reset", 0, homing_done_flag);
    rreg(`AZR_ADDR_POSITION, got);
    chk("position after reset", 0, got);
    $display("reset in motion done");
    tally_and_finish;
  end
endmodule
